// *** src/ueh_pkg.sv ***
package ueh_pkg;
  // special-function space offsets
  localparam logic [7:0] SFR_AP1_HI = 8'h9a;
  localparam logic [7:0] SFR_AP1_LO = 8'h9b;
  localparam logic [7:0] SFR_AP2_HI = 8'h9d;
  localparam logic [7:0] SFR_AP2_LO = 8'h9e;
  localparam logic [7:0] SFR_AP_SETUP = 8'haf;
  // external data space offsets
  localparam logic [15:0] XA_ERR_IE = 16'he662;
  localparam logic [15:0] XA_ERR_IRQ = 16'he663;
  localparam logic [15:0] XA_ERR_CNTLIM = 16'he664;
  localparam logic [15:0] XA_ERR_CLR = 16'he665;
  localparam logic [15:0] XA_TOGGLE = 16'he683;
  localparam logic [15:0] XA_AP1_DATA = 16'he67b;
  localparam logic [15:0] XA_AP2_DATA = 16'he67c;
  localparam logic [15:0] XA_SRC_HI = 16'he6b3;
  localparam logic [15:0] XA_SRC_LO = 16'he6b4;
  localparam logic [15:0] XA_SEND_CTL = 16'he6b5;
  // fetchable ranges for descriptor source
  localparam logic [15:0] MAIN_RAM_TOP = 16'h3fff;
  localparam logic [15:0] SCR_RAM_BASE = 16'he000;
  localparam logic [15:0] SCR_RAM_TOP = 16'he1ff;
  // reset values and field positions
  localparam logic [3:0] ERR_LIMIT_RST = 4'h4;
  localparam int IRQ_LIMIT_BIT = 0;
  localparam int ISO_ERR_LSB = 4;
  localparam int TOG_DIR_BIT = 4;
  localparam int TOG_CLR_BIT = 5;
  localparam int TOG_SET_BIT = 6;
  localparam int AP_EN_BIT = 0;
  localparam int AP1_INC_BIT = 1;
  localparam int AP2_INC_BIT = 2;
  localparam logic [6:0] EP0_MAX_PKT = 7'h40;
  localparam logic [7:0] DESC_LEN_OFS = 8'h00;
  typedef enum {SDP_IDLE, SDP_LEN, SDP_WAIT, SDP_FILL, SDP_ARM} ueh_sdp_t;
endpackage : ueh_pkg

// *** src/ueh_helper.sv ***
`timescale 1ns/1ps
// Contract
// - error limit in low nibble, 1..15
// - count bus errors, flag at limit
// - limit resets to four
// - count readable in upper nibble
// - any clear write zeroes count only
// - iso sequence error flags with enables
// - toggle control bit layout and readback
// - low pointer write starts packetised send
// - length from descriptor or byte count
// - send smaller of requested and available
// - manual byte count write never arms
// - fetch only main or scratch RAM (only the start address is checked)
// - data port access then optional increment
// - setup: shared enable, per-pointer increment
// - pointer address readable/writable anytime
// - code fetch hole when pointers enabled
// - data ports only in external space
// - flags write-one-clear, enables plain read/write
module ueh_helper (
  input wire logic mclk,
  input wire logic sys_rst,
  // special-function register port
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // external data space port
  input wire logic xd_wr,
  input wire logic xd_rd,
  input wire logic [15:0] xd_addr,
  input wire logic [7:0] xd_wdata,
  output logic [7:0] xd_rdata,
  output logic xd_hit,
  // code fetch port
  input wire logic code_rd,
  input wire logic [15:0] code_addr,
  output logic code_hole,
  output logic [7:0] code_rdata,
  // memory port used by pointers and descriptor sender
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // usb engine events
  input wire logic usb_err,
  input wire logic [3:0] iso_seq_err,
  input wire logic [3:0] tog_cur,
  output logic [4:0] tog_sel,
  output logic tog_clr,
  output logic tog_set,
  // endpoint zero side
  input wire logic [15:0] setup_wlength,
  input wire logic [15:0] control_ep_byte_count,
  input wire logic ep0_buf_ready,
  output logic ep0_wr,
  output logic [5:0] ep0_idx,
  output logic [7:0] ep0_data,
  output logic ep0_arm,
  output logic [6:0] ep0_pkt_len,
  output logic sdp_busy,
  output logic sdp_fault,
  output logic err_limit_hit
);
  import ueh_pkg::*;

  // error block registers
  logic [3:0] limit_ff; // programmed limit
  logic [3:0] cnt_ff; // running error count
  logic [7:0] irq_ff; // sticky flags
  logic [7:0] ie_ff; // enables
  logic [7:0] tog_ff; // toggle control latch
  // autopointers
  logic [15:0] ap1_ff, ap2_ff;
  logic [2:0] apset_ff;
  // descriptor sender
  logic [15:0] src_ff;
  logic auto_ff;
  ueh_sdp_t st_ff;
  logic [15:0] ptr_ff; // next fetch address
  logic [15:0] left_ff; // bytes still to send
  logic [6:0] idx_ff;
  logic [7:0] len_lo_ff;
  logic rd_pend_ff;
  // byte taken on the fetch cycle itself; the memory port moves on right
  // after, so sampling one edge later would pick up the following byte
  logic [7:0] fetch_ff;

  // external space decode
  wire w_ie = xd_wr && xd_addr == XA_ERR_IE;
  wire w_irq = xd_wr && xd_addr == XA_ERR_IRQ;
  wire w_lim = xd_wr && xd_addr == XA_ERR_CNTLIM;
  wire w_clr = xd_wr && xd_addr == XA_ERR_CLR;
  wire w_tog = xd_wr && xd_addr == XA_TOGGLE;
  wire w_shi = xd_wr && xd_addr == XA_SRC_HI;
  wire w_slo = xd_wr && xd_addr == XA_SRC_LO;
  wire w_sct = xd_wr && xd_addr == XA_SEND_CTL;
  wire ap1_x = (xd_wr || xd_rd) && xd_addr == XA_AP1_DATA;
  wire ap2_x = (xd_wr || xd_rd) && xd_addr == XA_AP2_DATA;
  wire hole1 = code_rd && apset_ff[AP_EN_BIT] && code_addr == XA_AP1_DATA;
  wire hole2 = code_rd && apset_ff[AP_EN_BIT] && code_addr == XA_AP2_DATA;
  wire ap1_acc = ap1_x || hole1;
  wire ap2_acc = ap2_x || hole2;
  wire inc1 = ap1_acc && apset_ff[AP1_INC_BIT];
  wire inc2 = ap2_acc && apset_ff[AP2_INC_BIT];
  wire ap_cycle = ap1_acc || ap2_acc;

  // descriptor source must lie in on-chip RAM
  function automatic logic in_ram(input logic [15:0] a);
    in_ram = a <= MAIN_RAM_TOP || (a >= SCR_RAM_BASE && a <= SCR_RAM_TOP);
  endfunction : in_ram

  wire [15:0] new_src = {src_ff[15:8], xd_wdata};
  wire src_ok = in_ram(new_src);
  wire cnt_full = cnt_ff == 4'hf;
  wire reach = usb_err && !cnt_full && (cnt_ff + 4'h1) == limit_ff;
  wire [7:0] irq_set = {iso_seq_err, 3'b000, reach};

  // error limit and count; a limit of zero is refused, count saturates
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      limit_ff <= ERR_LIMIT_RST;
      cnt_ff <= 4'h0;
    end else begin
      if (w_lim && xd_wdata[3:0] != 4'h0) begin
        limit_ff <= xd_wdata[3:0];
      end
      if (w_clr) begin
        cnt_ff <= 4'h0;
      end else if (usb_err && !cnt_full) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end

  // flags: hardware set beats a simultaneous write-one clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_ff <= 8'h00;
      ie_ff <= 8'h00;
    end else begin
      irq_ff <= (irq_ff & ~(w_irq ? xd_wdata : 8'h00)) | irq_set;
      if (w_ie) begin
        ie_ff <= xd_wdata & 8'hf1;
      end
    end
  end
  assign err_limit_hit = irq_ff[IRQ_LIMIT_BIT] & ie_ff[IRQ_LIMIT_BIT];

  // toggle control; clear and set are single-cycle requests
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tog_ff <= 8'h00;
      tog_clr <= 1'b0;
      tog_set <= 1'b0;
    end else begin
      tog_clr <= w_tog && xd_wdata[TOG_CLR_BIT];
      tog_set <= w_tog && xd_wdata[TOG_SET_BIT];
      if (w_tog) begin
        tog_ff <= {1'b0, xd_wdata[6:0]};
      end
    end
  end
  assign tog_sel = tog_ff[4:0];

  // autopointer address and setup registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ap1_ff <= 16'h0000;
      ap2_ff <= 16'h0000;
      apset_ff <= 3'b000;
    end else begin
      if (sfr_wr && sfr_addr == SFR_AP1_HI) ap1_ff[15:8] <= sfr_wdata;
      else if (sfr_wr && sfr_addr == SFR_AP1_LO) ap1_ff[7:0] <= sfr_wdata;
      else if (inc1) ap1_ff <= ap1_ff + 16'h0001;
      if (sfr_wr && sfr_addr == SFR_AP2_HI) ap2_ff[15:8] <= sfr_wdata;
      else if (sfr_wr && sfr_addr == SFR_AP2_LO) ap2_ff[7:0] <= sfr_wdata;
      else if (inc2) ap2_ff <= ap2_ff + 16'h0001;
      if (sfr_wr && sfr_addr == SFR_AP_SETUP) apset_ff <= sfr_wdata[2:0];
    end
  end

  // sfr read mux
  always_comb begin
    case (sfr_addr)
      SFR_AP1_HI: sfr_rdata = ap1_ff[15:8];
      SFR_AP1_LO: sfr_rdata = ap1_ff[7:0];
      SFR_AP2_HI: sfr_rdata = ap2_ff[15:8];
      SFR_AP2_LO: sfr_rdata = ap2_ff[7:0];
      SFR_AP_SETUP: sfr_rdata = {5'h00, apset_ff};
      default: sfr_rdata = 8'h00;
    endcase
  end

  // external read mux; data ports pass memory straight through
  always_comb begin
    xd_hit = 1'b1;
    case (xd_addr)
      XA_ERR_IE: xd_rdata = ie_ff;
      XA_ERR_IRQ: xd_rdata = irq_ff;
      XA_ERR_CNTLIM: xd_rdata = {cnt_ff, limit_ff};
      XA_TOGGLE: xd_rdata = {tog_cur[0], tog_ff[6:0]};
      XA_AP1_DATA: xd_rdata = mem_rdata;
      XA_AP2_DATA: xd_rdata = mem_rdata;
      XA_SRC_HI: xd_rdata = src_ff[15:8];
      XA_SRC_LO: xd_rdata = src_ff[7:0];
      XA_SEND_CTL: xd_rdata = {7'h00, auto_ff};
      default: begin
        xd_rdata = 8'h00;
        xd_hit = 1'b0;
      end
    endcase
  end
  assign code_hole = hole1 || hole2;
  assign code_rdata = code_hole ? mem_rdata : 8'h00;

  // memory port: pointer accesses take priority over the sender
  wire sdp_fetch = (st_ff == SDP_LEN || st_ff == SDP_FILL) && !ap_cycle;
  assign mem_rd = (ap_cycle && !xd_wr) || sdp_fetch;
  assign mem_wr = ap_cycle && xd_wr;
  assign mem_addr = ap1_acc ? ap1_ff : ap2_acc ? ap2_ff : ptr_ff;
  assign mem_wdata = xd_wdata;

  wire [15:0] want = setup_wlength;
  // smaller of requested and available length
  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    min16 = a < b ? a : b;
  endfunction : min16
  wire [15:0] pkt_left = left_ff < {9'h000, EP0_MAX_PKT} ? left_ff : {9'h000, EP0_MAX_PKT};

  // descriptor sender: fetch into ep0 buffer, arm, repeat until done
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      src_ff <= 16'h0000;
      auto_ff <= 1'b0;
      st_ff <= SDP_IDLE;
      ptr_ff <= 16'h0000;
      left_ff <= 16'h0000;
      idx_ff <= 7'h00;
      len_lo_ff <= 8'h00;
      rd_pend_ff <= 1'b0;
      sdp_fault <= 1'b0;
    end else begin
      rd_pend_ff <= 1'b0;
      if (w_shi) src_ff[15:8] <= xd_wdata;
      if (w_sct) auto_ff <= xd_wdata[0];
      case (st_ff)
        SDP_IDLE: begin
          if (w_slo) begin
            src_ff[7:0] <= xd_wdata;
            ptr_ff <= new_src;
            sdp_fault <= !src_ok;
            if (src_ok && auto_ff) begin
              st_ff <= SDP_LEN;
            end else if (src_ok) begin
              left_ff <= min16(want, control_ep_byte_count);
              st_ff <= SDP_WAIT;
            end
          end
        end
        SDP_LEN: begin
          if (!ap_cycle && !rd_pend_ff) rd_pend_ff <= 1'b1;
          if (rd_pend_ff) begin
            len_lo_ff <= mem_rdata;
            left_ff <= min16(want, {8'h00, mem_rdata});
            st_ff <= SDP_WAIT;
          end
        end
        SDP_WAIT: begin
          idx_ff <= 7'h00;
          if (left_ff == 16'h0000) st_ff <= SDP_IDLE;
          else if (ep0_buf_ready) st_ff <= SDP_FILL;
        end
        SDP_FILL: begin
          if (!ap_cycle) begin
            rd_pend_ff <= 1'b1;
            ptr_ff <= ptr_ff + 16'h0001;
            idx_ff <= idx_ff + 7'h01;
          end
          if ({9'h000, idx_ff} + 16'h0001 >= pkt_left && !ap_cycle) st_ff <= SDP_ARM;
        end
        SDP_ARM: begin
          // hold here until the last byte has reached the buffer, so the
          // host never sees a packet that is still being filled
          if (!rd_pend_ff && !ep0_wr) begin
            left_ff <= left_ff - pkt_left;
            st_ff <= SDP_WAIT;
          end
        end
        default: st_ff <= SDP_IDLE;
      endcase
    end
  end

  // buffer write lags the fetch by two cycles
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ep0_wr <= 1'b0;
      ep0_idx <= 6'h00;
      ep0_data <= 8'h00;
      fetch_ff <= 8'h00;
    end else begin
      // the length fetch in auto mode is not a payload byte
      ep0_wr <= rd_pend_ff && st_ff != SDP_LEN;
      // index lags the fetch counter by the one pipeline stage
      ep0_idx <= idx_ff[5:0] - 6'h01;
      // capture every cycle; only the cycle after a fetch is written out
      fetch_ff <= mem_rdata;
      ep0_data <= fetch_ff;
    end
  end
  // byte count writes never reach ep0_arm; only the sender arms
  // arm fires once, after the write pipeline has drained
  assign ep0_arm = st_ff == SDP_ARM && !ep0_wr && !rd_pend_ff;
  assign ep0_pkt_len = pkt_left[6:0];
  assign sdp_busy = st_ff != SDP_IDLE;

  AST_CLR_WINS: assert property (@(posedge mclk) disable iff (sys_rst)
    w_clr |=> cnt_ff == 4'h0) else $error("count not cleared");
  AST_SAT: assert property (@(posedge mclk) disable iff (sys_rst)
    cnt_full && !w_clr |=> cnt_full) else $error("count wrapped");
  AST_LIM_KEEP: assert property (@(posedge mclk) disable iff (sys_rst)
    w_clr && !w_lim |=> $stable(limit_ff)) else $error("limit disturbed");
  AST_LIM_RANGE: assert property (@(posedge mclk) disable iff (sys_rst)
    limit_ff != 4'h0) else $error("limit zero");
  AST_FLAG_SET: assert property (@(posedge mclk) disable iff (sys_rst)
    reach |=> irq_ff[IRQ_LIMIT_BIT]) else $error("limit flag missed");
  // the bench pulses the second endpoint's sequence error
  AST_ISO: assert property (@(posedge mclk) disable iff (sys_rst)
    iso_seq_err[1] |=> irq_ff[ISO_ERR_LSB + 1]) else $error("iso flag missed");
  AST_INC: assert property (@(posedge mclk) disable iff (sys_rst)
    inc1 && !sfr_wr |=> ap1_ff == $past(ap1_ff) + 16'h0001) else $error("no inc");
  AST_FREEZE: assert property (@(posedge mclk) disable iff (sys_rst)
    ap1_acc && !apset_ff[AP1_INC_BIT] && !sfr_wr |=> $stable(ap1_ff))
    else $error("frozen pointer moved");
  AST_FAULT: assert property (@(posedge mclk) disable iff (sys_rst)
    st_ff == SDP_IDLE && w_slo && !src_ok |=> st_ff == SDP_IDLE && sdp_fault)
    else $error("bad source started");
  AST_HOLE: assert property (@(posedge mclk) disable iff (sys_rst)
    code_rd && !apset_ff[AP_EN_BIT] |-> !code_hole) else $error("hole when off");
  // arming while a buffer write is still in flight would send a short packet
  AST_ARM_DRAIN: assert property (@(posedge mclk) disable iff (sys_rst)
    ep0_arm |-> !ep0_wr) else $error("armed during fill");
  // a length of zero must never be armed
  AST_ARM_LEN: assert property (@(posedge mclk) disable iff (sys_rst)
    ep0_arm |-> ep0_pkt_len != 7'h00) else $error("empty packet armed");
  // one arm per packet: the sender leaves the arm state right after
  AST_ARM_ONCE: assert property (@(posedge mclk) disable iff (sys_rst)
    ep0_arm |=> !ep0_arm) else $error("double arm");
  // a refused limit write of zero keeps the old limit
  AST_LIM_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
    w_lim && xd_wdata[3:0] == 4'h0 |=> $stable(limit_ff))
    else $error("zero limit taken");
  COV_LIMIT: cover property (@(posedge mclk) reach);
  COV_SEND: cover property (@(posedge mclk) st_ff == SDP_ARM);
  COV_TOG: cover property (@(posedge mclk) tog_clr);
  // a packet armed at the full endpoint-zero size
  COV_FULL_PKT: cover property (@(posedge mclk) ep0_arm && ep0_pkt_len == EP0_MAX_PKT);
  // a data-port access that steals the memory port from the sender
  COV_STALL: cover property (@(posedge mclk) st_ff == SDP_FILL && ap_cycle);
endmodule : ueh_helper

// *** testbench/ueh_mem_model.sv ***
`timescale 1ns/1ps
// far side: ram behind the pointers and host draining endpoint zero
module ueh_mem_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  input wire logic ep0_arm,
  output logic ep0_buf_ready
);
  // flat byte store, seeded with a pattern derived from the address
  logic [7:0] ram [0:65535];
  // host drain counter, the buffer is not ready again at once
  logic [3:0] busy_ff;
  initial begin
    for (int i = 0; i < 65536; i++) ram[i] = i[7:0] ^ 8'ha5;
  end
  // an idle bus shows a moving pattern so stale data never matches
  assign mem_rdata = mem_rd ? ram[mem_addr] : ~mem_addr[7:0];
  assign ep0_buf_ready = (busy_ff == 4'h0);
  // writes land on the edge; each armed packet stalls the sender
  always @(posedge mclk) begin
    if (mem_wr) ram[mem_addr] <= mem_wdata;
    if (sys_rst) busy_ff <= 4'h0;
    else if (ep0_arm) busy_ff <= 4'h6;
    else if (busy_ff != 4'h0) busy_ff <= busy_ff - 4'h1;
  end
endmodule : ueh_mem_model

// *** testbench/test_ueh_helper.sv ***
`timescale 1ns/1ps
module test_ueh_helper;
  import ueh_pkg::*;
  logic mclk, sys_rst, sfr_wr, sfr_rd, xd_wr, xd_rd, code_rd, usb_err;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xd_wdata, xd_rdata, code_rdata;
  logic [7:0] mem_wdata, mem_rdata, ep0_data, rd, last_b;
  logic [15:0] xd_addr, code_addr, mem_addr, setup_wlength, control_ep_byte_count;
  logic [3:0] iso_seq_err, tog_cur;
  logic [4:0] tog_sel;
  logic [5:0] ep0_idx;
  logic [6:0] ep0_pkt_len;
  logic xd_hit, code_hole, mem_rd, mem_wr, tog_clr, tog_set, ep0_buf_ready;
  logic ep0_wr, ep0_arm, sdp_busy, sdp_fault, err_limit_hit;
  int n_fail, cmp_count, n_wr, n_arm, n_clr, n_set;
  ueh_helper DUT (.mclk, .sys_rst, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata,
    .sfr_rdata, .xd_wr, .xd_rd, .xd_addr, .xd_wdata, .xd_rdata, .xd_hit,
    .code_rd, .code_addr, .code_hole, .code_rdata, .mem_rd, .mem_wr,
    .mem_addr, .mem_wdata, .mem_rdata, .usb_err, .iso_seq_err, .tog_cur,
    .tog_sel, .tog_clr, .tog_set, .setup_wlength, .control_ep_byte_count,
    .ep0_buf_ready, .ep0_wr, .ep0_idx, .ep0_data, .ep0_arm, .ep0_pkt_len,
    .sdp_busy, .sdp_fault, .err_limit_hit);
  ueh_mem_model mem (.mclk, .sys_rst, .mem_rd, .mem_wr, .mem_addr,
    .mem_wdata, .mem_rdata, .ep0_arm, .ep0_buf_ready);
  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  // event counters for pulses too short to poll
  always @(posedge mclk) begin
    if (ep0_wr === 1'b1) n_wr <= n_wr + 1;
    if (ep0_wr === 1'b1) last_b <= ep0_data;
    if (ep0_arm === 1'b1) n_arm <= n_arm + 1;
    if (tog_clr === 1'b1) n_clr <= n_clr + 1;
    if (tog_set === 1'b1) n_set <= n_set + 1;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask : chk
  // one-cycle strobes, launched and dropped on falling edges
  task automatic xwr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    {xd_wr, xd_addr, xd_wdata} = {1'b1, a, d};
    @(negedge mclk);
    xd_wr = 0;
  endtask : xwr
  task automatic xrd(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk);
    {xd_rd, xd_addr} = {1'b1, a};
    #1 d = xd_rdata;
    @(negedge mclk);
    xd_rd = 0;
  endtask : xrd
  task automatic swr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(negedge mclk);
    sfr_wr = 0;
  endtask : swr
  task automatic srd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    {sfr_rd, sfr_addr} = {1'b1, a};
    #1 d = sfr_rdata;
    @(negedge mclk);
    sfr_rd = 0;
  endtask : srd
  task automatic errs(input int n);
    repeat (n) begin
      @(negedge mclk) usb_err = 1;
      @(negedge mclk) usb_err = 0;
    end
  endtask : errs
  task automatic t_err;
    xrd(XA_ERR_CNTLIM, rd);
    chk(rd, 8'h04, "limit reset");
    xwr(XA_ERR_IE, 8'h01);
    xwr(XA_ERR_CNTLIM, 8'h03);
    xwr(XA_ERR_CNTLIM, 8'h00);
    errs(2);
    chk({7'h0, err_limit_hit}, 8'h00, "early hit");
    errs(1);
    chk({7'h0, err_limit_hit}, 8'h01, "limit hit");
    xrd(XA_ERR_CNTLIM, rd);
    chk(rd, 8'h33, "count");
    errs(13);
    xrd(XA_ERR_CNTLIM, rd);
    chk(rd, 8'hf3, "saturate");
    xwr(XA_ERR_CLR, 8'h5a);
    xrd(XA_ERR_CNTLIM, rd);
    chk(rd, 8'h03, "clear");
    xwr(XA_ERR_IRQ, 8'h01);
    xrd(XA_ERR_IRQ, rd);
    chk(rd, 8'h00, "w1c");
    @(negedge mclk) iso_seq_err = 4'h2;
    @(negedge mclk) iso_seq_err = 4'h0;
    xrd(XA_ERR_IRQ, rd);
    chk(rd, 8'h20, "iso flag");
  endtask : t_err
  task automatic t_tog;
    tog_cur = 4'h1;
    xwr(XA_TOGGLE, 8'h16);
    xwr(XA_TOGGLE, 8'h36);
    repeat (2) @(negedge mclk);
    chk(n_clr[7:0], 8'h01, "clr pulse");
    chk({3'h0, tog_sel}, 8'h16, "select");
    xrd(XA_TOGGLE, rd);
    chk({2'h0, rd[7], rd[4:0]}, 8'h36, "readback");
    xwr(XA_TOGGLE, 8'h45);
    repeat (2) @(negedge mclk);
    chk({n_set[3:0], 1'b0, tog_sel[2:0]}, 8'h15, "set");
  endtask : t_tog
  task automatic t_ap;
    swr(SFR_AP_SETUP, 8'h03);
    swr(SFR_AP1_HI, 8'h01);
    swr(SFR_AP1_LO, 8'hfe);
    xwr(XA_AP1_DATA, 8'h3c);
    chk(mem.ram[16'h01fe], 8'h3c, "ptr write");
    xrd(XA_AP1_DATA, rd);
    chk(rd, 8'h5a, "ptr read");
    srd(SFR_AP1_HI, rd);
    chk(rd, 8'h02, "carry");
    swr(SFR_AP2_HI, 8'h20);
    swr(SFR_AP2_LO, 8'h00);
    xrd(XA_AP2_DATA, rd);
    xrd(XA_AP2_DATA, rd);
    srd(SFR_AP2_LO, rd);
    chk(rd, 8'h00, "frozen");
    @(negedge mclk) {code_rd, code_addr} = {1'b1, 16'he67c};
    #1 chk({code_hole, code_rdata[6:0]}, 8'ha5, "hole");
    swr(SFR_AP_SETUP, 8'h00);
    #1 chk({7'h0, code_hole}, 8'h00, "no hole");
    code_rd = 0;
    xrd(16'h1234, rd);
    chk({xd_hit, rd[6:0]}, 8'h00, "unmapped");
  endtask : t_ap
  task automatic send(input logic [7:0] hi, input logic [7:0] exp_n);
    int k;
    k = 0;
    n_wr = 0;
    n_arm = 0;
    xwr(XA_SRC_HI, hi);
    xwr(XA_SRC_LO, 8'h00);
    while (sdp_busy !== 1'b0 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    repeat (4) @(negedge mclk);
    chk(n_wr[7:0], exp_n, "bytes sent");
  endtask : send
  // firmware side: the handshake hold is assumed already released, and
  // every start address handed to send() is even
  task automatic t_sdp;
    mem.ram[16'h0100] = 8'h12;
    setup_wlength = 16'h00ff;
    xwr(XA_SEND_CTL, 8'h01);
    send(8'h01, 8'd18);
    chk({n_arm[3:0], 4'h0} | 8'h0, 8'h10, "auto arm");
    chk(last_b, 8'hb4, "auto data");
    xwr(XA_SEND_CTL, 8'h00);
    control_ep_byte_count = 16'd100;
    setup_wlength = 16'd70;
    repeat (2) @(negedge mclk);
    chk({7'h0, sdp_busy}, 8'h00, "no arm");
    send(8'h01, 8'd70);
    chk(n_arm[7:0], 8'h02, "packets");
    chk(last_b, 8'he0, "manual data");
    control_ep_byte_count = 16'd4;
    send(8'he0, 8'd4);
    send(8'h80, 8'd0);
    chk({7'h0, sdp_fault}, 8'h01, "fault");
  endtask : t_sdp
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #60000;
    n_fail++;
    test_done();
  end
  initial begin
    {sys_rst, sfr_wr, sfr_rd, xd_wr, xd_rd, code_rd, usb_err} = 7'h40;
    {sfr_addr, sfr_wdata, xd_wdata, xd_addr, code_addr} = '0;
    {iso_seq_err, tog_cur, setup_wlength, control_ep_byte_count} = '0;
    {n_fail, cmp_count, n_wr, n_arm, n_clr, n_set} = '0;
    repeat (5) @(negedge mclk);
    sys_rst = 0;
    t_err();
    t_tog();
    t_ap();
    t_sdp();
    test_done();
  end
endmodule : test_ueh_helper
